//--- core/iprc_level_reg.sv
// One 3-bit priority field with reset value and write strobe.
// Assumes write data is already extracted from the bus word.
`timescale 1ns/1ps
`default_nettype none
module iprc_level_reg
  import iprc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             we_i,
  input  wire logic [IPRC_LW-1:0] wdat_i,
  output logic      [IPRC_LW-1:0] level_o,
  output logic                  enabled_o
);

  logic [IPRC_LW-1:0] lvl_q;
  logic [IPRC_LW-1:0] lvl_d;

  // Next value: new level takes effect next edge, no further step needed
  always_comb begin
    lvl_d = lvl_q;
    if (we_i) begin
      lvl_d = wdat_i;
    end
  end

  // Reset loads level 4 (msb set, lower bits clear)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= IPRC_LVL_RST;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  assign level_o   = lvl_q;
  // Level zero keeps the source out of arbitration
  assign enabled_o = (lvl_q != IPRC_LVL_OFF);

endmodule : iprc_level_reg
`default_nettype wire

//--- core/iprc_pkg.sv
// Package for the interrupt priority register pair: offsets, field layout,
// reset values and level encoding.
// Assumes a 16-bit register view carried on a 32-bit classic Wishbone bus.
package iprc_pkg;

  localparam int          IPRC_AW        = 4;
  localparam int          IPRC_DW        = 32;
  localparam int          IPRC_RW        = 16;
  localparam int          IPRC_LW        = 3;
  // Byte offsets of the two registers
  localparam logic [3:0]  IPRC_OFS_CN    = 4'h0;
  localparam logic [3:0]  IPRC_OFS_CMP   = 4'h4;
  // Least significant bit of each priority field
  localparam int          IPRC_CN_LSB    = 12;
  localparam int          IPRC_CMP3_LSB  = 12;
  localparam int          IPRC_CMP2_LSB  = 8;
  localparam int          IPRC_CMP1_LSB  = 4;
  // Level encoding
  localparam logic [2:0]  IPRC_LVL_OFF   = 3'h0;
  localparam logic [2:0]  IPRC_LVL_MIN   = 3'h1;
  localparam logic [2:0]  IPRC_LVL_MAX   = 3'h7;
  localparam logic [2:0]  IPRC_LVL_RST   = 3'h4;
  // Writable bit masks
  localparam logic [15:0] IPRC_CN_MASK   = 16'h7000;
  localparam logic [15:0] IPRC_CMP_MASK  = 16'h7770;

endpackage : iprc_pkg

//--- core/iprc_top.sv
// Interrupt priority registers for pin change notification and comparators
// 1 to 3, reached over classic Wishbone (32-bit data, 16 bits used).
// Assumes a single clock and synchronous active-high reset from the system.
`timescale 1ns/1ps
`default_nettype none
module iprc_top
  import iprc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [IPRC_AW-1:0] wb_adr_i,
  input  wire logic [IPRC_DW-1:0] wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  output logic      [IPRC_DW-1:0] wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    wb_err_o,
  output logic      [IPRC_LW-1:0] pin_change_irq_level_o,
  output logic      [IPRC_LW-1:0] cmp3_irq_level_o,
  output logic      [IPRC_LW-1:0] cmp2_irq_level_o,
  output logic      [IPRC_LW-1:0] cmp1_irq_level_o,
  output logic      [3:0]         src_enabled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic               req;
  logic               hit_cn;
  logic               hit_cmp;
  logic               wr_ok;
  logic               ack_q;
  logic               ack_d;
  logic               err_q;
  logic               err_d;
  logic [IPRC_DW-1:0] dat_q;
  logic [IPRC_DW-1:0] dat_d;
  logic [IPRC_RW-1:0] cn_word;
  logic [IPRC_RW-1:0] cmp_word;

  // Field extraction used by every write port
  function automatic logic [IPRC_LW-1:0] fld(input logic [IPRC_DW-1:0] w,
                                             input int lsb);
    fld = w[lsb +: IPRC_LW];
  endfunction : fld

  // New request only while no answer is standing, so each cycle gets one ack or one err
  assign req     = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign hit_cn  = (wb_adr_i == IPRC_OFS_CN);
  assign hit_cmp = (wb_adr_i == IPRC_OFS_CMP);
  // Fields live in bits 14:4, so byte lanes 0 and 1 gate them
  assign wr_ok   = req && wb_we_i;

  logic we_cn_hi;
  logic we_cmp_hi;
  logic we_cmp_lo;
  assign we_cn_hi  = wr_ok && hit_cn && wb_sel_i[1];
  assign we_cmp_hi = wr_ok && hit_cmp && wb_sel_i[1];
  assign we_cmp_lo = wr_ok && hit_cmp && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Priority fields

  logic [3:0] en;

  iprc_level_reg u_cn (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (we_cn_hi),
    .wdat_i    (fld(wb_dat_i, IPRC_CN_LSB)),
    .level_o   (pin_change_irq_level_o),
    .enabled_o (en[0])
  );

  iprc_level_reg u_cmp3 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (we_cmp_hi),
    .wdat_i    (fld(wb_dat_i, IPRC_CMP3_LSB)),
    .level_o   (cmp3_irq_level_o),
    .enabled_o (en[3])
  );

  iprc_level_reg u_cmp2 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (we_cmp_hi),
    .wdat_i    (fld(wb_dat_i, IPRC_CMP2_LSB)),
    .level_o   (cmp2_irq_level_o),
    .enabled_o (en[2])
  );

  iprc_level_reg u_cmp1 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (we_cmp_lo),
    .wdat_i    (fld(wb_dat_i, IPRC_CMP1_LSB)),
    .level_o   (cmp1_irq_level_o),
    .enabled_o (en[1])
  );

  assign src_enabled_o = en;

  ////////////////////////////////////////////////////////////////////////////
  // Read words and answer

  // Unused positions are constant zero; writes there have nowhere to land
  always_comb begin
    cn_word  = '0;
    cmp_word = '0;
    cn_word[IPRC_CN_LSB +: IPRC_LW]    = pin_change_irq_level_o;
    cmp_word[IPRC_CMP3_LSB +: IPRC_LW] = cmp3_irq_level_o;
    cmp_word[IPRC_CMP2_LSB +: IPRC_LW] = cmp2_irq_level_o;
    cmp_word[IPRC_CMP1_LSB +: IPRC_LW] = cmp1_irq_level_o;
    cn_word  = cn_word & IPRC_CN_MASK;
    cmp_word = cmp_word & IPRC_CMP_MASK;
  end

  // One-cycle ack for mapped offsets, err for anything else
  always_comb begin
    ack_d = req && (hit_cn || hit_cmp);
    err_d = req && !(hit_cn || hit_cmp);
    dat_d = '0;
    if (req && !wb_we_i && hit_cn) begin
      dat_d = {16'h0000, cn_word};
    end else if (req && !wb_we_i && hit_cmp) begin
      dat_d = {16'h0000, cmp_word};
    end
  end

  // Answer registers; data is cleared outside a read so idle lanes never leak levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      err_q <= err_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_cmp_write;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o
      && wb_adr_i == IPRC_OFS_CMP && wb_sel_i[1];
  endsequence

  a_reset_level: assert property (@(posedge clk_i)
    $past(rst_i) |-> pin_change_irq_level_o == IPRC_LVL_RST
      && cmp3_irq_level_o == IPRC_LVL_RST && cmp2_irq_level_o == IPRC_LVL_RST
      && cmp1_irq_level_o == IPRC_LVL_RST)
    else $error("field not at level 4 after reset");

  a_cn_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && hit_cn && wb_sel_i[1]) |=>
      pin_change_irq_level_o == $past(wb_dat_i[14:12]))
    else $error("pin change level not written");

  a_cmp3_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmp_write |=> cmp3_irq_level_o == $past(wb_dat_i[14:12]))
    else $error("comparator 3 level not written");

  a_cmp2_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmp_write |=> cmp2_irq_level_o == $past(wb_dat_i[10:8]))
    else $error("comparator 2 level not written");

  a_cmp1_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && hit_cmp && wb_sel_i[0]) |=>
      cmp1_irq_level_o == $past(wb_dat_i[6:4]))
    else $error("comparator 1 level not written");

  a_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o & ~{16'h0000, IPRC_CMP_MASK}) == '0)
    else $error("unused bit read as one");

  a_cn_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && hit_cn) |-> (wb_dat_o & ~{16'h0000, IPRC_CN_MASK}) == '0)
    else $error("unused change notify bit read as one");

  a_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");

  a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !hit_cn && !hit_cmp) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");

  a_zero_off: assert property (@(posedge clk_i) disable iff (rst_i)
    src_enabled_o == {(cmp3_irq_level_o != IPRC_LVL_OFF), (cmp2_irq_level_o != IPRC_LVL_OFF),
                      (cmp1_irq_level_o != IPRC_LVL_OFF),
                      (pin_change_irq_level_o != IPRC_LVL_OFF)})
    else $error("enable does not follow level");

  a_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) ##1 !$past(rst_i) |-> $stable(cmp2_irq_level_o))
    else $error("level changed without a write");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule : iprc_top
`default_nettype wire

//--- dv/iprc_bench.sv
// Self-checking bench for the interrupt priority register pair.
// Assumes iprc_top with classic Wishbone, one clock and sync reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module iprc_bench;
  import iprc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, err;
  logic [3:0]  adr, sel, en;
  logic [31:0] wdat, rdat, r;
  logic [2:0]  lp, l3, l2, l1;
  logic        e;
  int          error_cnt, checks_done;
  iprc_top i_iprc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .pin_change_irq_level_o(lp),
    .cmp3_irq_level_o(l3), .cmp2_irq_level_o(l2), .cmp1_irq_level_o(l1),
    .src_enabled_o(en));
  ////////////////////////////////////////////////////////////////////////////
  // 4 ns clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Verdict, reached from the main flow and from any timeout
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // One classic cycle; the request holds until ack or err is seen at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    r = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
    `CHK(e, 1'b0)
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(e, 1'b0)
    `CHK(r, x)
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IPRC_OFS_CN, 32'h00004000);
    rd(IPRC_OFS_CMP, 32'h00004440);
    `CHK({lp, l3, l2, l1, en}, 16'h924f)
    $display("test reset values done");
    wr(IPRC_OFS_CN, 32'hffffffff, 4'hf);
    rd(IPRC_OFS_CN, 32'h00007000);
    wr(IPRC_OFS_CMP, 32'hffffffff, 4'hf);
    rd(IPRC_OFS_CMP, 32'h00007770);
    $display("test field masks done");
    wr(IPRC_OFS_CMP, 32'h00001230, 4'hf);
    `CHK({lp, l3, l2, l1}, 12'he53)
    rd(IPRC_OFS_CMP, 32'h00001230);
    wr(IPRC_OFS_CN, 32'h00000000, 4'hf);
    `CHK(en, 4'he)
    wr(IPRC_OFS_CMP, 32'h00000000, 4'h1);
    rd(IPRC_OFS_CMP, 32'h00001200);
    `CHK(en, 4'hc)
    wr(IPRC_OFS_CMP, 32'h00000740, 4'h2);
    rd(IPRC_OFS_CMP, 32'h00000700);
    $display("test levels and lanes done");
    bus(1'b1, 4'h8, 32'hffffffff, 4'hf);
    `CHK(e, 1'b1)
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0)
    rd(IPRC_OFS_CN, 32'h00000000);
    rd(IPRC_OFS_CMP, 32'h00000700);
    $display("test unmapped done");
    // Mid-run reset must bring every field back to level 4
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IPRC_OFS_CN, 32'h00004000);
    rd(IPRC_OFS_CMP, 32'h00004440);
    `CHK({lp, l3, l2, l1, en}, 16'h924f)
    $display("test mid-run reset done");
    conclude();
  end
endmodule : iprc_bench
`default_nettype wire
